// ===== verilog/sdi_sdram_core.sv
`timescale 1ns/1ps
// Functional notes
// - Every input is sampled on the rising clock edge only.
// - Four banks, each 4096 rows of 256 columns of 32-bit words.
// - ACTIVE picks bank and row; READ or WRITE to that bank follows.
// - READ or WRITE takes the low eight address bits as start column.
// - Mode word loaded with both bank selects zero; kept until reloaded.
// - A mode load puts the data outputs into high impedance.
// - Mode word holds span, order, latency, operating mode, write-single bits.
// - Spans 1, 2, 4, 8 in both orders; full row sequential only.
// - Full-row burst runs until a burst terminate, a mode load, or a new READ or WRITE to an open bank.
// - Spans 2, 4, 8 wrap inside an aligned block of span size.
// - Full-row burst increments and wraps within the same row.
// - Sequential visits start plus i; interleaved visits start xor i.
// - Span one accesses the given column and ignores the order bit.
// - Read at edge n drives from edge n+m-1, valid by n+m.
// - With the write-single bit set, writes access one column only.
module sdi_sdram_core (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clock_gate_input,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_enable_n,
  input wire logic bank_select_high,
  input wire logic bank_select_low,
  input wire logic [sdi_pkg::ROW_W-1:0] addr,
  input wire logic [sdi_pkg::DATA_W-1:0] dq_in,
  output logic [sdi_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic mode_loaded,
  output logic [sdi_pkg::NUM_BANKS-1:0] bank_active
);
  import sdi_pkg::*;

  typedef struct packed {
    logic [NUM_BANKS-1:0][ROW_W-1:0] rows;
    logic [NUM_BANKS-1:0] open;
    logic [MODE_W-1:0] mode;
    logic mode_ok;
    logic [BANK_W-1:0] bbank;
    logic [ROW_W-1:0] brow;
    logic [PIPE_DEPTH-1:0] pipe_v;
    logic [PIPE_DEPTH-1:0][DATA_W-1:0] pipe_d;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
    logic [FIFO_DEPTH-1:0][ENTRY_W-1:0] fifo;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
  } sdi_core_state_t;

  sdi_core_state_t s_q;
  sdi_core_state_t s_d;

  // Storage for all four banks, one word per column
  logic [DATA_W-1:0] mem_q [0:NUM_WORDS-1];

  sdi_burst_if bif ();

  sdi_burst_seq u_seq (
    .clk_sys(clk_sys),
    .reset(reset),
    .bif(bif)
  );

  function automatic sdi_cmd_t cmd_decode(input logic cs_n, input logic ras_n,
                                         input logic cas_n, input logic we_n);
    if (cs_n)
      return CMD_INHIBIT;
    case ({ras_n, cas_n, we_n})
      3'b111: return CMD_NOP;
      3'b011: return CMD_ACTIVE;
      3'b101: return CMD_READ;
      3'b100: return CMD_WRITE;
      3'b110: return CMD_TERM;
      3'b010: return CMD_PRE;
      3'b001: return CMD_REFRESH;
      default: return CMD_LOAD;
    endcase
  endfunction

  sdi_cmd_t cmd;
  logic [BANK_W-1:0] bank_in;
  logic start_ok;
  logic fifo_full;
  logic read_use;
  logic push;
  logic pop;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] rd_word;
  logic [FIFO_DEPTH-1:0][ENTRY_W-1:0] fifo_now;
  logic [LAT_W-1:0] lat_code;

  assign bank_in = {bank_select_high, bank_select_low};
  // Clock gate low blocks new commands; the burst in flight carries on
  assign cmd = clock_gate_input ?
               cmd_decode(chip_select_n, row_strobe_n, col_strobe_n, write_enable_n) :
               CMD_INHIBIT;
  // Bursts to a closed bank or before the mode word is known are ignored
  assign start_ok = (cmd == CMD_READ || cmd == CMD_WRITE) && s_q.open[bank_in] &&
                    s_q.mode_ok;
  assign fifo_full = (s_q.count == COUNT_FULL);
  assign read_use = bif.busy && !bif.cur_write;
  assign push = bif.busy && bif.cur_write && !fifo_full;
  // Array has a single port: a read beat holds the write drain back
  assign pop = (s_q.count != 2'h0) && !read_use;
  assign fifo_now = s_q.fifo;
  assign lat_code = s_q.mode[LAT_LSB +: LAT_W];

  assign bif.start = start_ok;
  assign bif.stop = (cmd == CMD_TERM) || (cmd == CMD_LOAD);
  assign bif.is_write = (cmd == CMD_WRITE);
  assign bif.start_col = addr[COL_W-1:0];
  assign bif.span_code = (cmd == CMD_WRITE && s_q.mode[WSINGLE_POS]) ?
                         SPAN_1 : s_q.mode[SPAN_LSB +: SPAN_W];
  assign bif.interleaved = s_q.mode[ORDER_POS];
  // A full buffer pauses the burst rather than dropping a word
  assign bif.advance = !(bif.cur_write && fifo_full);

  // The first beat uses the bank and row named with the command itself
  assign acc_addr = bif.start ? {bank_in, s_q.rows[bank_in], bif.cur_col} :
                                {s_q.bbank, s_q.brow, bif.cur_col};

  // Reads see writes still waiting in the buffer, newest entry first
  always_comb
  begin
    logic older;
    logic newer;
    older = s_q.rd_ptr;
    newer = !s_q.rd_ptr;
    rd_word = mem_q[acc_addr];
    if (s_q.count != 2'h0 && fifo_now[older][ENTRY_W-1 -: ADDR_W] == acc_addr)
      rd_word = fifo_now[older][DATA_W-1:0];
    if (s_q.count == COUNT_FULL && fifo_now[newer][ENTRY_W-1 -: ADDR_W] == acc_addr)
      rd_word = fifo_now[newer][DATA_W-1:0];
  end

  always_comb
  begin
    logic sel_v;
    logic [DATA_W-1:0] sel_d;
    sel_v = 1'b0;
    sel_d = s_q.dq_out;
    s_d = s_q;

    case (cmd)
      CMD_ACTIVE:
      begin
        s_d.rows[bank_in] = addr;
        s_d.open[bank_in] = 1'b1;
      end
      CMD_PRE:
      begin
        if (addr[PRE_ALL_POS])
          s_d.open = '0;
        else
          s_d.open[bank_in] = 1'b0;
      end
      CMD_LOAD:
      begin
        // Nonzero bank selects address reserved space and are ignored
        if (bank_in == 2'h0)
        begin
          s_d.mode = addr;
          s_d.mode_ok = 1'b1;
        end
      end
      default:
      begin
        s_d.mode = s_q.mode;
      end
    endcase

    if (bif.start)
    begin
      s_d.bbank = bank_in;
      s_d.brow = s_q.rows[bank_in];
    end

    // Read data pipeline; latency picks the tap that feeds the pins
    s_d.pipe_v[0] = read_use;
    s_d.pipe_d[0] = rd_word;
    s_d.pipe_v[1] = s_q.pipe_v[0];
    s_d.pipe_d[1] = s_q.pipe_d[0];
    case (lat_code)
      LAT_2:
      begin
        sel_v = s_q.pipe_v[0];
        sel_d = s_q.pipe_d[0];
      end
      LAT_3:
      begin
        sel_v = s_q.pipe_v[1];
        sel_d = s_q.pipe_d[1];
      end
      default:
      begin
        // Latency one and reserved codes drive at the command edge
        sel_v = read_use;
        sel_d = rd_word;
      end
    endcase
    s_d.dq_oe = sel_v;
    if (sel_v)
      s_d.dq_out = sel_d;

    if (cmd == CMD_LOAD)
    begin
      s_d.pipe_v = '0;
      s_d.dq_oe = 1'b0;
    end

    // Write buffer, two entries of address and data
    if (push)
    begin
      s_d.fifo[s_q.wr_ptr] = {acc_addr, dq_in};
      s_d.wr_ptr = !s_q.wr_ptr;
    end
    if (pop)
      s_d.rd_ptr = !s_q.rd_ptr;
    if (push && !pop)
      s_d.count = 2'(s_q.count + 2'h1);
    else if (pop && !push)
      s_d.count = 2'(s_q.count - 2'h1);

    if (reset)
    begin
      s_d = '0;
      s_d.mode = MODE_RESET;
    end
  end

  always_ff @(posedge clk_sys)
    s_q <= s_d;

  // Storage is not cleared by reset, as in the real array
  always_ff @(posedge clk_sys)
  begin
    if (pop && !reset)
      mem_q[fifo_now[s_q.rd_ptr][ENTRY_W-1 -: ADDR_W]] <= fifo_now[s_q.rd_ptr][DATA_W-1:0];
  end

  assign dq_out = s_q.dq_out;
  assign dq_oe = s_q.dq_oe;
  assign mode_loaded = s_q.mode_ok;
  assign bank_active = s_q.open;
endmodule

// ===== verilog/sdi_pkg.sv
package sdi_pkg;
  localparam int BANK_W = 2;
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int DATA_W = 32;
  localparam int MODE_W = 12;
  localparam int NUM_BANKS = 4;
  localparam int NUM_ROWS = 4096;
  localparam int NUM_COLS = 256;
  localparam int NUM_WORDS = NUM_BANKS * NUM_ROWS * NUM_COLS;
  localparam int ADDR_W = BANK_W + ROW_W + COL_W;
  localparam int ENTRY_W = ADDR_W + DATA_W;
  localparam int FIFO_DEPTH = 2;
  localparam int PIPE_DEPTH = 2;

  // Mode word field positions and the precharge-all address bit
  localparam int SPAN_LSB = 0;
  localparam int SPAN_W = 3;
  localparam int ORDER_POS = 3;
  localparam int LAT_LSB = 4;
  localparam int LAT_W = 3;
  localparam int OPMODE_LSB = 7;
  localparam int WSINGLE_POS = 9;
  localparam int PRE_ALL_POS = 10;

  localparam logic [SPAN_W-1:0] SPAN_1 = 3'h0;
  localparam logic [SPAN_W-1:0] SPAN_2 = 3'h1;
  localparam logic [SPAN_W-1:0] SPAN_4 = 3'h2;
  localparam logic [SPAN_W-1:0] SPAN_8 = 3'h3;
  localparam logic [SPAN_W-1:0] SPAN_FULL = 3'h7;
  localparam logic [LAT_W-1:0] LAT_1 = 3'h1;
  localparam logic [LAT_W-1:0] LAT_2 = 3'h2;
  localparam logic [LAT_W-1:0] LAT_3 = 3'h3;

  // Contents are undefined at power-up; this value is arbitrary
  localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;
  localparam logic [1:0] COUNT_FULL = 2'h2;

  typedef enum logic [3:0] {
    CMD_INHIBIT = 4'b0000,
    CMD_NOP = 4'b0001,
    CMD_ACTIVE = 4'b0010,
    CMD_READ = 4'b0011,
    CMD_WRITE = 4'b0100,
    CMD_TERM = 4'b0101,
    CMD_PRE = 4'b0110,
    CMD_REFRESH = 4'b0111,
    CMD_LOAD = 4'b1000
  } sdi_cmd_t;

  typedef enum logic [1:0] {
    BS_IDLE = 2'b00,
    BS_READ = 2'b01,
    BS_WRITE = 2'b10
  } sdi_burst_state_t;

  // Index of the last access in a span; reserved codes act as one column
  function automatic logic [COL_W-1:0] span_last(input logic [SPAN_W-1:0] span);
    case (span)
      SPAN_2: return 8'h01;
      SPAN_4: return 8'h03;
      SPAN_8: return 8'h07;
      SPAN_FULL: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction
endpackage

// ===== verilog/sdi_burst_if.sv
`timescale 1ns/1ps
interface sdi_burst_if;
  import sdi_pkg::*;
  logic start;
  logic stop;
  logic is_write;
  logic [COL_W-1:0] start_col;
  logic [SPAN_W-1:0] span_code;
  logic interleaved;
  logic advance;
  logic [COL_W-1:0] cur_col;
  logic busy;
  logic cur_write;

  modport ctrl (
    output start, stop, is_write, start_col, span_code, interleaved, advance,
    input cur_col, busy, cur_write
  );
  modport seq (
    input start, stop, is_write, start_col, span_code, interleaved, advance,
    output cur_col, busy, cur_write
  );
endinterface

// ===== verilog/sdi_burst_seq.sv
`timescale 1ns/1ps
module sdi_burst_seq (
  input wire logic clk_sys,
  input wire logic reset,
  sdi_burst_if.seq bif
);
  import sdi_pkg::*;

  typedef struct packed {
    sdi_burst_state_t state;
    logic [COL_W-1:0] start;
    logic [COL_W-1:0] idx;
    logic [SPAN_W-1:0] span;
    logic inter;
  } sdi_seq_state_t;

  sdi_seq_state_t s_q;
  sdi_seq_state_t s_d;

  function automatic logic [COL_W-1:0] col_at(input logic [COL_W-1:0] start,
                                              input logic [COL_W-1:0] idx,
                                              input logic [SPAN_W-1:0] span,
                                              input logic inter);
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] low;
    mask = span_last(span);
    low = (inter && span != SPAN_FULL) ? (start ^ idx) : COL_W'(start + idx);
    return (start & ~mask) | (low & mask);
  endfunction

  assign bif.busy = bif.start || (s_q.state != BS_IDLE);
  assign bif.cur_write = bif.start ? bif.is_write : (s_q.state == BS_WRITE);
  assign bif.cur_col = bif.start ? bif.start_col : col_at(s_q.start, s_q.idx, s_q.span, s_q.inter);

  always_comb
  begin
    logic [COL_W-1:0] idx_now;
    logic [SPAN_W-1:0] span_now;
    idx_now = bif.start ? '0 : s_q.idx;
    span_now = bif.start ? bif.span_code : s_q.span;
    s_d = s_q;
    if (bif.start)
    begin
      s_d.state = bif.is_write ? BS_WRITE : BS_READ;
      s_d.start = bif.start_col;
      s_d.span = bif.span_code;
      s_d.inter = bif.interleaved;
      s_d.idx = '0;
    end
    if (bif.busy && bif.advance)
    begin
      // A full row never ends by itself, only by a stop or a new start
      if (span_now != SPAN_FULL && idx_now == span_last(span_now))
        s_d.state = BS_IDLE;
      else
        s_d.idx = COL_W'(idx_now + 8'h01);
    end
    if (bif.stop)
      s_d.state = BS_IDLE;
    if (reset)
      s_d = '0;
  end

  always_ff @(posedge clk_sys)
    s_q <= s_d;
endmodule

// ===== verif/sdi_ctrl_model.sv
`timescale 1ns/1ps
module sdi_ctrl_model #(
  parameter int INIT_CYC = 20,
  parameter int WAIT_CYC = 2
) (
  input wire logic clk_sys,
  output logic gate,
  output logic [3:0] cmd,
  output logic [1:0] bank,
  output logic [11:0] addr,
  output logic [31:0] dq
);
  initial
  begin
    gate = 1'b0;
    cmd = 4'hF;
    bank = 2'h0;
    addr = 12'h000;
    dq = 32'h0000_0000;
  end
  task automatic put(logic [3:0] c, logic [1:0] b, logic [11:0] a, logic [31:0] d);
    @(posedge clk_sys);
    #1;
    cmd = c;
    bank = b;
    addr = a;
    dq = d;
  endtask
  // Released data lines flip so a stale word never looks written
  task automatic go(logic [3:0] c, logic [1:0] b, logic [11:0] a);
    put(c, b, a, ~dq);
  endtask
  task automatic nop(int n);
    repeat (n) go(4'hF, bank, addr);
  endtask
  task automatic load(logic [1:0] b, logic [11:0] mw);
    go(4'h0, b, mw);
    nop(WAIT_CYC);
  endtask
  // Waits are cycle counts, shrunk for a short run
  task automatic init_seq();
    nop(INIT_CYC / 2);
    gate = 1'b1;
    nop(INIT_CYC / 2);
    go(4'h2, 2'h0, 12'h400);
    nop(WAIT_CYC);
    repeat (2)
    begin
      go(4'h1, 2'h0, 12'h000);
      nop(WAIT_CYC);
    end
  endtask
endmodule

// ===== verif/sdi_sdram_core_monitor.sv
`timescale 1ns/1ps
module sdi_sdram_core_monitor (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clock_gate_input,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_enable_n,
  input wire logic bank_select_high,
  input wire logic bank_select_low,
  input wire logic [sdi_pkg::ROW_W-1:0] addr,
  input wire logic [sdi_pkg::DATA_W-1:0] dq_in,
  input wire logic [sdi_pkg::DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic mode_loaded,
  input wire logic [sdi_pkg::NUM_BANKS-1:0] bank_active
);
  import sdi_pkg::*;
  logic [3:0] c;
  logic [1:0] b;
  logic [MODE_W-1:0] mode_q;
  logic rd;
  // Gate low turns every command into an inhibit
  assign c = clock_gate_input ? {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} : 4'hF;
  assign b = {bank_select_high, bank_select_low};
  assign rd = c == 4'h5 && bank_active[b] && mode_loaded;
  always_ff @(posedge clk_sys)
    mode_q <= reset ? MODE_RESET : (c == 4'h0 && b == 2'h0) ? addr : mode_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_LOAD_FLAG: assert property (c == 4'h0 && b == 2'h0 |=> mode_loaded)
    else $error("mode load lost");
  AST_BAD_LOAD: assert property (c == 4'h0 && b != 2'h0 && !mode_loaded |=> !mode_loaded)
    else $error("bad mode load taken");
  AST_LOAD_HIZ: assert property (c == 4'h0 && b == 2'h0 |=> !dq_oe)
    else $error("driving after mode load");
  AST_ACT: assert property (c == 4'h3 |=> bank_active[$past(b)])
    else $error("row not opened");
  AST_LAT1: assert property (rd && mode_q[6:4] == LAT_1 |=> dq_oe)
    else $error("latency one late");
  AST_LAT3: assert property (rd && mode_q[6:4] == LAT_3 && !dq_oe |=> !dq_oe ##1 !dq_oe ##1 dq_oe)
    else $error("latency three wrong");
  AST_SPAN8: assert property ($rose(dq_oe) && mode_q[2:0] == SPAN_8 |-> dq_oe [*8] ##1 !dq_oe)
    else $error("span eight length");
  AST_TERM: assert property (c == 4'h6 && dq_oe |-> ##[1:4] !dq_oe)
    else $error("burst not stopped");
  CV_LOAD: cover property (c == 4'h0 && b == 2'h0);
  CV_TERM: cover property (c == 4'h6 && dq_oe);
  CV_SPAN8: cover property ($rose(dq_oe) && mode_q[2:0] == SPAN_8);
endmodule
bind sdi_sdram_core sdi_sdram_core_monitor sdi_sdram_core_monitor_i (
  .clk_sys(clk_sys),
  .reset(reset),
  .clock_gate_input(clock_gate_input),
  .chip_select_n(chip_select_n),
  .row_strobe_n(row_strobe_n),
  .col_strobe_n(col_strobe_n),
  .write_enable_n(write_enable_n),
  .bank_select_high(bank_select_high),
  .bank_select_low(bank_select_low),
  .addr(addr),
  .dq_in(dq_in),
  .dq_out(dq_out),
  .dq_oe(dq_oe),
  .mode_loaded(mode_loaded),
  .bank_active(bank_active)
);

// ===== verif/sdi_sdram_core_tb.sv
`timescale 1ns/1ps
module sdi_sdram_core_tb;
  import sdi_pkg::*;
  localparam logic [1:0] BK = 2'h1;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic gate;
  logic [3:0] cmd;
  logic [1:0] bank;
  logic [11:0] addr;
  logic [31:0] dq;
  logic [DATA_W-1:0] dq_out;
  logic dq_oe;
  logic mode_loaded;
  logic [NUM_BANKS-1:0] bank_active;
  logic [31:0] mem [int];
  logic [31:0] exp_q [$];
  int err_total = 0;
  int num_checks = 0;
  int seed = 29128;
  int cyc = 0;
  sdi_ctrl_model sdi_ctrl_model_i (.clk_sys(clk_sys), .gate(gate), .cmd(cmd), .bank(bank),
    .addr(addr), .dq(dq));
  sdi_sdram_core sdi_sdram_core_i (.clk_sys(clk_sys), .reset(reset),
    .clock_gate_input(gate), .chip_select_n(cmd[3]), .row_strobe_n(cmd[2]),
    .col_strobe_n(cmd[1]), .write_enable_n(cmd[0]), .bank_select_high(bank[1]),
    .bank_select_low(bank[0]), .addr(addr), .dq_in(dq), .dq_out(dq_out), .dq_oe(dq_oe),
    .mode_loaded(mode_loaded), .bank_active(bank_active));
  always #10 clk_sys = ~clk_sys;
  function automatic int col_at(int st, int n, bit il, int i);
    int o;
    o = st % n;
    return st - o + (il ? (o ^ i) : ((o + i) % n));
  endfunction
  task automatic cmp_word(logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %0t word %h, expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_flag(logic e, logic g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %0t flag %b, expected %b", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(int st, int n, bit il, int beats);
    logic [31:0] d;
    for (int i = 0; i < beats; i++)
    begin
      d = $random(seed);
      mem[col_at(st, n, il, i)] = d;
      sdi_ctrl_model_i.put(i == 0 ? 4'h4 : 4'hF, BK, 12'(st), d);
    end
  endtask
  task automatic rd(int st, int n, bit il, int beats);
    for (int i = 0; i < beats; i++)
      exp_q.push_back(mem[col_at(st, n, il, i)]);
    sdi_ctrl_model_i.go(4'h5, BK, 12'(st));
  endtask
  // Mode loads need all banks idle, so every change closes rows first
  task automatic setup(logic [11:0] mw);
    sdi_ctrl_model_i.go(4'h2, 2'h0, 12'h400);
    sdi_ctrl_model_i.nop(2);
    sdi_ctrl_model_i.load(2'h0, mw);
    sdi_ctrl_model_i.go(4'h3, BK, 12'h5A5);
    sdi_ctrl_model_i.nop(1);
  endtask
  always @(posedge clk_sys)
  begin
    if (dq_oe === 1'b1 && exp_q.size() == 0)
      cmp_flag(1'b0, dq_oe);
    else if (dq_oe === 1'b1)
      cmp_word(exp_q.pop_front(), dq_out);
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      summarize();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    sdi_ctrl_model_i.init_seq();
    sdi_ctrl_model_i.load(2'h2, 12'h023);
    cmp_flag(1'b0, mode_loaded);
    sdi_ctrl_model_i.go(4'h3, BK, 12'h5A5);
    rd(1, 1, 0, 0);
    sdi_ctrl_model_i.nop(6);
    setup(12'h023);
    cmp_flag(1'b1, mode_loaded);
    cmp_word(32'h0000_0002, 32'(bank_active));
    wr(0, 8, 0, 8);
    wr(250, 8, 0, 8);
    sdi_ctrl_model_i.nop(4);
    for (int k = 0; k < 8; k++)
    begin
      setup({5'h00, 3'(k % 3 + 1), 1'(k % 2), 3'(k / 2)});
      rd($random(seed) & 7, 1 << (k / 2), 1'(k % 2), 1 << (k / 2));
      sdi_ctrl_model_i.nop(12);
      cmp_flag(1'b1, exp_q.size() == 0);
    end
    setup(12'h017);
    rd(254, 256, 0, 8);
    sdi_ctrl_model_i.nop(3);
    sdi_ctrl_model_i.go(4'h6, BK, 12'h000);
    sdi_ctrl_model_i.nop(8);
    cmp_flag(1'b1, exp_q.size() > 0);
    exp_q.delete();
    setup(12'h222);
    wr(3, 1, 0, 1);
    sdi_ctrl_model_i.nop(4);
    rd(1, 4, 0, 4);
    sdi_ctrl_model_i.nop(10);
    cmp_flag(1'b1, exp_q.size() == 0);
    summarize();
  end
endmodule
